// >>> hdl/fwsr_top.sv
// Host-side controller that runs flash data-polling and toggle-bit status algorithms.
//
// Behaviour
// - Host polls a program at the address being programmed.
// - Host polls an erase inside a sector selected for erasure.
// - Host takes the full data word only from a later read cycle.
// - Reads may be paced by output-enable or chip-select strobe.
// - Host reads at least twice and compares toggle bit; equal means done.
// - Toggling with timeout flag: recheck once; still toggling means fail, reset.
// - Host returning to toggle polling restarts the algorithm from the top.
// - Timeout flag seen in data polling: reread polling bit before failing.
module fwsr_top
   import fwsr_pkg::*;
(
   input  wire logic             CORE_CLK_IN,
   input  wire logic             RESET_N_IN,
   input  wire fwsr_apb_req_type APB_IN,
   output fwsr_apb_rsp_type      APB_OUT,
   output fwsr_pins_type         FLASH_OUT,
   input  wire logic [DQ_W-1:0]  FLASH_DQ_IN,
   input  wire logic             FLASH_RYBY_IN
);

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_POLL   = 3'b001,
      S_RECHK  = 3'b010,
      S_FINAL  = 3'b011,
      S_RSTCMD = 3'b100
   } fwsr_seq_type;

   typedef struct packed {
      fwsr_seq_type      st;
      fwsr_mode_type     mode;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   expect_word;
      logic [DQ_W-1:0]   prev;
      logic              have_prev;
      logic              done;
      logic              fail;
      logic              tmo;
      logic              tog2;
      logic [DQ_W-1:0]   rdata;
      fwsr_cyc_req_type  cyc;
      fwsr_apb_rsp_type  apb;
      logic              ryby_s1;
      logic              ryby_s2;
   } fwsr_top_state_type;

   fwsr_top_state_type s;
   fwsr_top_state_type next_s;
   fwsr_cyc_rsp_type   eng_rsp;
   logic               got;
   logic               wr_take;
   logic [DQ_W-1:0]    word;

   function automatic logic reg_hit(input logic [APB_A_W-1:0] a);
      return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_EXP) ||
             (a == OFS_STAT) || (a == OFS_RDATA);
   endfunction

   function automatic fwsr_cyc_req_type mk_req(input logic wr,
                                               input logic [ADDR_W-1:0] a,
                                               input logic [DQ_W-1:0] d);
      return '{req: 1'b1, write: wr, addr: a, wdata: d};
   endfunction

   function automatic logic [31:0] read_word(input logic [APB_A_W-1:0] a,
                                             input fwsr_top_state_type q);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         OFS_CTRL:  r[CTRL_MODE +: 2] = q.mode;
         OFS_ADDR:  r[ADDR_W-1:0] = q.addr;
         OFS_EXP:   r[DQ_W-1:0] = q.expect_word;
         OFS_STAT: begin
            r[STAT_BUSY] = (q.st != S_IDLE);
            r[STAT_DONE] = q.done;
            r[STAT_FAIL] = q.fail;
            r[STAT_TMO]  = q.tmo;
            r[STAT_TOG2] = q.tog2;
            r[STAT_RYBY] = q.ryby_s2;
            r[STAT_CYC]  = q.cyc.req;
         end
         OFS_RDATA: r[DQ_W-1:0] = q.rdata;
         default:   r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   assign got     = s.cyc.req && eng_rsp.ack;
   assign word    = eng_rsp.rdata;
   assign wr_take = APB_IN.psel && APB_IN.penable && APB_IN.pwrite && s.apb.pready;

   always_comb begin
      next_s             = s;
      next_s.apb.pready  = 1'b0;
      next_s.apb.pslverr = 1'b0;
      next_s.apb.prdata  = 32'h0000_0000;
      next_s.ryby_s1     = FLASH_RYBY_IN;
      next_s.ryby_s2     = s.ryby_s1;

      // One wait state gives a registered read word and a registered pready.
      if (APB_IN.psel && APB_IN.penable && !s.apb.pready) begin
         next_s.apb.pready  = 1'b1;
         next_s.apb.pslverr = !reg_hit(APB_IN.paddr);
         if (!APB_IN.pwrite) begin
            next_s.apb.prdata = read_word(APB_IN.paddr, s);
         end
      end

      if (got) begin
         next_s.cyc.req = 1'b0;
         case (s.st)
            S_POLL: begin
               if (s.mode == MODE_DATA) begin
                  if (word[POLL_BIT] == s.expect_word[POLL_BIT]) begin
                     next_s.st  = S_FINAL;
                     next_s.cyc = mk_req(1'b0, s.addr, '0);
                  end else if (word[TMO_BIT]) begin
                     // Polling bit and timeout flag may flip together, so look once more.
                     next_s.tmo = 1'b1;
                     next_s.st  = S_RECHK;
                     next_s.cyc = mk_req(1'b0, s.addr, '0);
                  end else begin
                     next_s.cyc = mk_req(1'b0, s.addr, '0);
                  end
               end else if (!s.have_prev) begin
                  next_s.prev      = word;
                  next_s.have_prev = 1'b1;
                  next_s.cyc       = mk_req(1'b0, s.addr, '0);
               end else if (word[TOG1_BIT] == s.prev[TOG1_BIT]) begin
                  next_s.st  = S_FINAL;
                  next_s.cyc = mk_req(1'b0, s.addr, '0);
               end else begin
                  next_s.prev = word;
                  next_s.tog2 = (word[TOG2_BIT] != s.prev[TOG2_BIT]);
                  if (word[TMO_BIT]) begin
                     next_s.tmo = 1'b1;
                     next_s.st  = S_RECHK;
                  end
                  next_s.cyc = mk_req(1'b0, s.addr, '0);
               end
            end
            S_RECHK: begin
               if ((s.mode == MODE_DATA) ? (word[POLL_BIT] == s.expect_word[POLL_BIT])
                                         : (word[TOG1_BIT] == s.prev[TOG1_BIT])) begin
                  next_s.st  = S_FINAL;
                  next_s.cyc = mk_req(1'b0, s.addr, '0);
               end else begin
                  next_s.fail = 1'b1;
                  next_s.st   = S_RSTCMD;
                  next_s.cyc  = mk_req(1'b1, s.addr, RESET_CMD);
               end
            end
            S_FINAL: begin
               // In the polling modes the word is taken only from a read after status said complete.
               next_s.rdata = word;
               next_s.done  = 1'b1;
               next_s.st    = S_IDLE;
            end
            S_RSTCMD: begin
               next_s.done = 1'b1;
               next_s.st   = S_IDLE;
            end
            default: next_s.st = S_IDLE;
         endcase
      end

      if (wr_take) begin
         case (APB_IN.paddr)
            OFS_CTRL: begin
               if (APB_IN.pwdata[CTRL_ABORT] && s.st != S_IDLE) begin
                  // A cycle already on the pins finishes and its answer is dropped.
                  next_s.st        = S_IDLE;
                  next_s.have_prev = 1'b0;
               end else if (APB_IN.pwdata[CTRL_GO] && s.st == S_IDLE && !s.cyc.req) begin
                  next_s.mode      = fwsr_mode_type'(APB_IN.pwdata[CTRL_MODE +: 2]);
                  next_s.done      = 1'b0;
                  next_s.fail      = 1'b0;
                  next_s.tmo       = 1'b0;
                  next_s.tog2      = 1'b0;
                  next_s.have_prev = 1'b0;
                  case (fwsr_mode_type'(APB_IN.pwdata[CTRL_MODE +: 2]))
                     MODE_READ: begin
                        next_s.st  = S_FINAL;
                        next_s.cyc = mk_req(1'b0, s.addr, '0);
                     end
                     MODE_RESET: begin
                        next_s.st  = S_RSTCMD;
                        next_s.cyc = mk_req(1'b1, s.addr, RESET_CMD);
                     end
                     default: begin
                        next_s.st  = S_POLL;
                        next_s.cyc = mk_req(1'b0, s.addr, '0);
                     end
                  endcase
               end
            end
            OFS_ADDR: begin
               if (s.st == S_IDLE) begin
                  next_s.addr = APB_IN.pwdata[ADDR_W-1:0];
               end
            end
            OFS_EXP: begin
               if (s.st == S_IDLE) begin
                  next_s.expect_word = APB_IN.pwdata[DQ_W-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign APB_OUT = s.apb;

   fwsr_cycle u_cycle (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESET_N_IN),
      .req_in   (s.cyc),
      .dq_in    (FLASH_DQ_IN),
      .rsp_out  (eng_rsp),
      .pins_out (FLASH_OUT)
   );

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   a_poll_address: assert property (
      (s.st == S_POLL && !FLASH_OUT.oe_n) |-> FLASH_OUT.addr == s.addr)
      else $error("Status read not at the polled address.");

   a_recheck_address: assert property (
      (s.st == S_RECHK && !FLASH_OUT.oe_n) |-> FLASH_OUT.addr == s.addr && FLASH_OUT.ce_n == 1'b0)
      else $error("Recheck read not at the polled address.");

   a_final_word: assert property (
      (s.st == S_FINAL && got) |=> s.done && s.st == S_IDLE && s.rdata == $past(word))
      else $error("Final read word not stored on completion.");

   a_two_reads: assert property (
      (s.st == S_POLL && s.mode == MODE_TOGGLE && got && !s.have_prev)
      |=> s.st == S_POLL && s.have_prev && s.cyc.req)
      else $error("Toggle decision made from a single read.");

   a_toggle_fail: assert property (
      (s.st == S_RECHK && s.mode == MODE_TOGGLE && got && word[TOG1_BIT] != s.prev[TOG1_BIT])
      |=> s.st == S_RSTCMD && s.fail && s.cyc.write && s.cyc.wdata == RESET_CMD)
      else $error("Persistent toggling did not lead to a reset command.");

   a_abort_restart: assert property (
      (wr_take && APB_IN.paddr == OFS_CTRL && APB_IN.pwdata[CTRL_ABORT] && s.st != S_IDLE)
      |=> s.st == S_IDLE && !s.have_prev)
      else $error("Abort did not return the algorithm to its first step.");

   a_timeout_reread: assert property (
      (s.st == S_POLL && s.mode == MODE_DATA && got &&
       word[POLL_BIT] != s.expect_word[POLL_BIT] && word[TMO_BIT])
      |=> s.st == S_RECHK && s.tmo && !s.fail)
      else $error("Timeout flag not followed by a polling bit reread.");

   a_fail_after_recheck: assert property (
      $rose(s.fail) |-> $past(s.st) == S_RECHK)
      else $error("Failure declared without a recheck read.");

endmodule // fwsr_top

// >>> shared/fwsr_pkg.sv
// Shared constants and carrier types for the flash status polling controller.
package fwsr_pkg;

   localparam int CLK_MHZ    = 40;
   localparam int ACC_NS     = 70;
   localparam int ACC_CYC    = (ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_CYC   = 2;
   localparam logic [3:0] PULSE_CYC = 4'(ACC_CYC + SYNC_CYC);

   localparam int ADDR_W     = 22;
   localparam int DQ_W       = 16;
   localparam int APB_A_W    = 12;

   localparam logic [APB_A_W-1:0] OFS_CTRL  = 12'h000;
   localparam logic [APB_A_W-1:0] OFS_ADDR  = 12'h004;
   localparam logic [APB_A_W-1:0] OFS_EXP   = 12'h008;
   localparam logic [APB_A_W-1:0] OFS_STAT  = 12'h00C;
   localparam logic [APB_A_W-1:0] OFS_RDATA = 12'h010;

   localparam int CTRL_GO     = 0;
   localparam int CTRL_MODE   = 1;
   localparam int CTRL_ABORT  = 3;
   localparam int STAT_BUSY   = 0;
   localparam int STAT_DONE   = 1;
   localparam int STAT_FAIL   = 2;
   localparam int STAT_TMO    = 3;
   localparam int STAT_TOG2   = 4;
   localparam int STAT_RYBY   = 5;
   localparam int STAT_CYC    = 6;

   localparam int POLL_BIT    = 7;
   localparam int TOG1_BIT    = 6;
   localparam int TMO_BIT     = 5;
   localparam int TOG2_BIT    = 2;

   localparam logic [DQ_W-1:0] RESET_CMD = 16'h00F0;

   typedef enum logic [1:0] {
      MODE_DATA   = 2'b00,
      MODE_TOGGLE = 2'b01,
      MODE_READ   = 2'b10,
      MODE_RESET  = 2'b11
   } fwsr_mode_type;

   typedef struct packed {
      logic               psel;
      logic               penable;
      logic               pwrite;
      logic [APB_A_W-1:0] paddr;
      logic [31:0]        pwdata;
   } fwsr_apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } fwsr_apb_rsp_type;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   dq_out;
      logic              dq_oe;
   } fwsr_pins_type;

   localparam fwsr_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                          addr: '0, dq_out: '0, dq_oe: 1'b0};

   typedef struct packed {
      logic              req;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   wdata;
   } fwsr_cyc_req_type;

   typedef struct packed {
      logic            ack;
      logic [DQ_W-1:0] rdata;
   } fwsr_cyc_rsp_type;

endpackage

// >>> hdl/fwsr_cycle.sv
// One read or write bus cycle on the flash pins, with data input synchroniser.
module fwsr_cycle
   import fwsr_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire fwsr_cyc_req_type  req_in,
   input  wire logic [DQ_W-1:0]   dq_in,
   output fwsr_cyc_rsp_type       rsp_out,
   output fwsr_pins_type          pins_out
);

   typedef enum logic [1:0] {
      E_IDLE  = 2'b00,
      E_SETUP = 2'b01,
      E_PULSE = 2'b10,
      E_REC   = 2'b11
   } fwsr_eng_type;

   typedef struct packed {
      fwsr_eng_type     st;
      logic [3:0]       cnt;
      logic [DQ_W-1:0]  sync1;
      logic [DQ_W-1:0]  sync2;
      fwsr_pins_type    pins;
      fwsr_cyc_rsp_type rsp;
   } fwsr_eng_state_type;

   fwsr_eng_state_type s;
   fwsr_eng_state_type next_s;

   always_comb begin
      next_s         = s;
      next_s.rsp.ack = 1'b0;
      next_s.sync1   = dq_in;
      next_s.sync2   = s.sync1;
      case (s.st)
         E_IDLE: begin
            if (req_in.req) begin
               next_s.st          = E_SETUP;
               next_s.pins.addr   = req_in.addr;
               next_s.pins.dq_out = req_in.wdata;
               next_s.pins.dq_oe  = req_in.write;
               next_s.pins.ce_n   = 1'b0;
            end
         end
         E_SETUP: begin
            next_s.st  = E_PULSE;
            next_s.cnt = PULSE_CYC;
            if (s.pins.dq_oe) begin
               next_s.pins.we_n = 1'b0;
            end else begin
               next_s.pins.oe_n = 1'b0;
            end
         end
         E_PULSE: begin
            if (s.cnt == 4'h1) begin
               // Every read ends with both strobes high so the device sees one completed cycle.
               next_s.st        = E_REC;
               next_s.pins.ce_n = 1'b1;
               next_s.pins.oe_n = 1'b1;
               next_s.pins.we_n = 1'b1;
               next_s.rsp.ack   = 1'b1;
               next_s.rsp.rdata = s.sync2;
            end else begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         E_REC: begin
            // Write data stays driven one cycle past the write strobe for hold time.
            next_s.st         = E_IDLE;
            next_s.pins.dq_oe = 1'b0;
         end
         default: next_s.st = E_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s <= '{st: E_IDLE, cnt: '0, sync1: '0, sync2: '0, pins: PINS_IDLE, rsp: '0};
      end else begin
         s <= next_s;
      end
   end

   assign rsp_out  = s.rsp;
   assign pins_out = s.pins;

   a_read_strobe_end: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (s.rsp.ack && !s.pins.dq_oe) |-> $past(!s.pins.oe_n) && s.pins.oe_n && s.pins.ce_n)
      else $error("Read answer without a completed output-enable strobe.");

endmodule // fwsr_cycle

// >>> test/fwsr_flash_model.sv
// Behavioural model of the flash device that reports program and erase status on its pins.
module fwsr_flash_model
   import fwsr_pkg::*;
(
   input  wire logic              ce_n_in,
   input  wire logic              oe_n_in,
   input  wire logic              we_n_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic [DQ_W-1:0]        dq_out,
   output logic                   ryby_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic              busy = 1'b0;
   logic              erase = 1'b0;
   logic              tmo = 1'b0;
   logic              tog1 = 1'b0;
   logic              tog2 = 1'b0;
   logic              erased = 1'b0;
   logic              progd = 1'b0;
   logic              prot = 1'b0;
   logic              susp = 1'b0;
   logic [ADDR_W-1:0] pa = '0;
   logic [DQ_W-1:0]   pd = '0;
   logic [DQ_W-1:0]   last = '0;
   logic [DQ_W-1:0]   status;
   logic [DQ_W-1:0]   drive_word;
   int unsigned       reads_left = 0;
   int unsigned       resets = 0;
   wire               rd_on = !ce_n_in && !oe_n_in;
   wire               wr_on = !ce_n_in && !we_n_in;
   wire               in_bank = (addr_in[ADDR_W-1] == pa[ADDR_W-1]);

   // While prot is set, the upper half of each bank stands for its protected sectors.
   function automatic logic prot_hit(input logic [ADDR_W-1:0] a);
      return prot && a[ADDR_W-2];
   endfunction

   function automatic logic [DQ_W-1:0] array_word(input logic [ADDR_W-1:0] a);
      if (progd && a == pa) return pd;
      if (erased && a[ADDR_W-1] == pa[ADDR_W-1] && !prot_hit(a)) return 16'hFFFF;
      return a[15:0] ^ 16'hA5A5;
   endfunction

   // Status is valid as soon as the command is taken; the bench calls this at command end.
   task automatic start_op(input logic is_erase, input logic [ADDR_W-1:0] a,
                           input logic [DQ_W-1:0] d, input int unsigned n, input logic t);
      busy = 1'b1;
      erase = is_erase;
      pa = a;
      pd = d;
      reads_left = n;
      tmo = t;
      tog1 = 1'b0;
      tog2 = 1'b0;
      progd = 1'b0;
      erased = 1'b0;
   endtask

   always_comb begin
      status = {8'h00, (erase ? susp : ~pd[7]), tog1, tmo, 2'b00,
                (erase && in_bank) ? tog2 : 1'b0, 2'b00};
      drive_word = (busy && in_bank) ? status : array_word(addr_in);
      dq_out = rd_on ? drive_word : ~last;
   end

   // A read ends when either strobe rises, so both pacing styles advance the toggle state.
   always @(negedge rd_on) begin
      last = drive_word;
      if (busy) begin
         if (!susp) begin
            tog1 = ~tog1;
         end
         if (erase && in_bank) begin
            tog2 = ~tog2;
         end
         if (!tmo) begin
            if (reads_left > 0) reads_left--;
            if (reads_left == 0) begin
               busy = 1'b0;
               progd = !erase && !prot_hit(pa);
               erased = erase;
            end
         end
      end
   end

   always @(negedge wr_on) begin
      if (dq_in[7:0] == 8'hF0) begin
         busy = 1'b0;
         tmo = 1'b0;
         resets++;
      end
   end

   // Open drain: the pin is only ever pulled low, never driven high.
   assign ryby_oe_out = busy;

endmodule // fwsr_flash_model

// >>> test/testbench.sv
// Self-checking bench for the flash status polling controller over its register bus.
module testbench
   import fwsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             core_clk = 1'b0;
   logic             rst_n = 1'b0;
   fwsr_apb_req_type apb_req = '0;
   fwsr_apb_rsp_type apb_rsp;
   fwsr_pins_type    pins;
   logic [DQ_W-1:0]  flash_dq;
   logic             ryby_oe;
   wire [DQ_W-1:0]   dq_wire = pins.dq_oe ? pins.dq_out : flash_dq;
   wire              ryby = ryby_oe ? 1'b0 : 1'b1;
   int               mismatches = 0;
   int               total_checks = 0;
   int               cycles = 0;
   logic [31:0]      st;
   logic [31:0]      rd;
   logic             err;

   fwsr_top u_fwsr_top (
      .CORE_CLK_IN   (core_clk),
      .RESET_N_IN    (rst_n),
      .APB_IN        (apb_req),
      .APB_OUT       (apb_rsp),
      .FLASH_OUT     (pins),
      .FLASH_DQ_IN   (dq_wire),
      .FLASH_RYBY_IN (ryby)
   );

   fwsr_flash_model u_fwsr_flash_model (
      .ce_n_in     (pins.ce_n),
      .oe_n_in     (pins.oe_n),
      .we_n_in     (pins.we_n),
      .addr_in     (pins.addr),
      .dq_in       (dq_wire),
      .dq_out      (flash_dq),
      .ryby_oe_out (ryby_oe)
   );

   always #12.5 core_clk = ~core_clk;

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Generous ceiling: every test together needs well under a tenth of it.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Holds the request until pready is seen high at a rising edge, whatever the wait.
   task automatic apb(input logic wr, input logic [APB_A_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rdata, output logic perr);
      @(posedge core_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
      rdata = apb_rsp.prdata;
      perr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic rdc(input logic [APB_A_W-1:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, v, e);
      check(what, exp, v);
   endtask

   task automatic run_poll(input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] e,
                           input fwsr_mode_type m, output logic [31:0] s);
      int          n;
      logic [31:0] v;
      logic        pe;
      apb(1'b1, OFS_ADDR, 32'(a), v, pe);
      apb(1'b1, OFS_EXP, 32'(e), v, pe);
      apb(1'b1, OFS_CTRL, 32'({m, 1'b1}), v, pe);
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0000_0000, s, pe);
         n++;
      end while (s[STAT_DONE] !== 1'b1 && n < 500);
   endtask

   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;

      rdc(OFS_STAT, 32'h0000_0020, "status after reset");
      rdc(OFS_ADDR, 32'h0000_0000, "address after reset");
      rdc(OFS_EXP, 32'h0000_0000, "expected word after reset");
      rdc(OFS_RDATA, 32'h0000_0000, "read data after reset");
      apb(1'b0, 12'h014, 32'h0000_0000, rd, err);
      check("unmapped error", 32'h0000_0001, 32'(err));
      check("unmapped data", 32'h0000_0000, rd);
      $display("test reset values done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_1234, 16'h5A3C, 3, 1'b0);
      run_poll(22'h00_1234, 16'h5A3C, MODE_DATA, st);
      check("program poll status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_5A3C, "program final word");
      $display("test data poll program done");

      u_fwsr_flash_model.start_op(1'b1, 22'h20_0100, 16'h0000, 4, 1'b0);
      run_poll(22'h20_0100, 16'h0080, MODE_DATA, st);
      check("erase poll status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_FFFF, "erase final word");
      $display("test data poll erase done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_0400, 16'h1289, 5, 1'b0);
      run_poll(22'h00_0400, 16'h1289, MODE_TOGGLE, st);
      check("toggle poll status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_1289, "toggle final word");
      $display("test toggle poll done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_0010, 16'h0011, 0, 1'b1);
      repeat (4) @(posedge core_clk);
      rdc(OFS_STAT, 32'h0000_0002, "status while device busy");
      run_poll(22'h00_0010, 16'h0011, MODE_DATA, st);
      check("data timeout status", 32'h0000_000E, 32'(st[3:0]));
      check("data timeout reset", 32'd1, 32'(u_fwsr_flash_model.resets));
      $display("test data poll timeout done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_0020, 16'h0011, 0, 1'b1);
      run_poll(22'h00_0020, 16'h0011, MODE_TOGGLE, st);
      check("toggle timeout status", 32'h0000_000E, 32'(st[3:0]));
      check("toggle timeout reset", 32'd2, 32'(u_fwsr_flash_model.resets));
      $display("test toggle poll timeout done");

      u_fwsr_flash_model.prot = 1'b1;
      u_fwsr_flash_model.start_op(1'b0, 22'h10_0060, 16'h0011, 3, 1'b0);
      run_poll(22'h10_0060, 16'h0011, MODE_TOGGLE, st);
      check("protected program status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_A5C5, "protected program word");
      u_fwsr_flash_model.start_op(1'b1, 22'h20_0100, 16'h0000, 3, 1'b0);
      run_poll(22'h20_0100, 16'h0080, MODE_DATA, st);
      check("partial erase status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_FFFF, "unprotected sector erased");
      run_poll(22'h30_0042, 16'h0000, MODE_READ, st);
      rdc(OFS_RDATA, 32'h0000_A5E7, "protected sector kept");
      u_fwsr_flash_model.prot = 1'b0;
      $display("test protected sectors done");

      u_fwsr_flash_model.start_op(1'b1, 22'h20_0100, 16'h0000, 50, 1'b0);
      u_fwsr_flash_model.susp = 1'b1;
      run_poll(22'h20_0100, 16'h0000, MODE_TOGGLE, st);
      check("suspend poll status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_0080, "suspended erase status word");
      u_fwsr_flash_model.susp = 1'b0;
      $display("test erase suspend done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_0050, 16'h1289, 8, 1'b0);
      apb(1'b1, OFS_ADDR, 32'h0000_0050, rd, err);
      apb(1'b1, OFS_CTRL, 32'h0000_0003, rd, err);
      repeat (3) apb(1'b0, OFS_STAT, 32'h0000_0000, rd, err);
      apb(1'b1, OFS_CTRL, 32'h0000_0008, rd, err);
      apb(1'b0, OFS_STAT, 32'h0000_0000, st, err);
      check("status after abort", 32'h0000_0000, 32'(st[5:0]));
      repeat (8) @(posedge core_clk);
      run_poll(22'h00_0050, 16'h1289, MODE_TOGGLE, st);
      check("restart status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_1289, "restart final word");
      $display("test abort restart done");

      u_fwsr_flash_model.start_op(1'b0, 22'h00_0030, 16'h0044, 1000, 1'b0);
      run_poll(22'h20_0042, 16'h0000, MODE_READ, st);
      check("plain read status", 32'h0000_0002, 32'(st[3:0]));
      rdc(OFS_RDATA, 32'h0000_A5E7, "idle bank word");
      $display("test read idle bank done");

      run_poll(22'h00_0030, 16'h0000, MODE_RESET, st);
      check("reset mode status", 32'h0000_0002, 32'(st[3:0]));
      check("reset mode command", 32'd3, 32'(u_fwsr_flash_model.resets));
      check("device left busy", 32'h0000_0000, 32'(u_fwsr_flash_model.busy));
      repeat (4) @(posedge core_clk);
      rdc(OFS_STAT, 32'h0000_0022, "status after reset command");
      $display("test reset mode done");

      end_sim();
   end

endmodule // testbench
